// >>> design/qfb_defs.vh
// register map, field positions, codes and timing counts for the flash bus controller
`ifndef QFB_DEFS_VH
`define QFB_DEFS_VH

`define QFB_OFS_MCMD   8'h00
`define QFB_OFS_MADR   8'h04
`define QFB_OFS_MOPT   8'h08
`define QFB_OFS_MEN    8'h0c
`define QFB_OFS_MRD    8'h10
`define QFB_OFS_MWR    8'h14
`define QFB_OFS_MCTL   8'h18
`define QFB_OFS_DCMD   8'h20
`define QFB_OFS_DOPT   8'h24
`define QFB_OFS_DEN    8'h28
`define QFB_OFS_DCTL   8'h2c

`define QFB_RST_REG    32'h00000000

// command codes register
`define QFB_CMD_LSB    16
`define QFB_SECOND_COMMAND_CODE_LSB   0
// phase enables register
`define QFB_CMDW_LSB   30
`define QFB_OCMDW_LSB  28
`define QFB_ADRW_LSB   24
`define QFB_OPTW_LSB   20
`define QFB_XFRW_LSB   16
`define QFB_CMDON_BIT  14
`define QFB_OCMDON_BIT 12
`define QFB_ADRL_LSB   8
`define QFB_OPTL_LSB   4
`define QFB_XFRL_LSB   0
// manual control register
`define QFB_START_BIT  0
`define QFB_TXAL_BIT   1
`define QFB_RXAL_BIT   2
`define QFB_MHOLD_BIT  8
// mapped control register
`define QFB_BON_BIT    8
`define QFB_FLUSH_BIT  9
`define QFB_BLEN_LSB   16
`define QFB_BHOLD_BIT  24

`define QFB_W_SINGLE   2'h0
`define QFB_W_DUAL     2'h1
`define QFB_W_QUAD     2'h2
`define QFB_ADR_32     4'hf

`define QFB_WIN_MAIN   6'h06
`define QFB_WIN_ALIAS  6'h0e

`define QFB_SCLK_CYC   2
`define QFB_RX_LAG     5

`endif

// >>> design/qfb_ctrl.v
// serial flash controller: apb registers, manual transfers, mapped reads with burst cache
//
// The APB register port and the placing of the registers were left to the implementer.
`include "qfb_defs.vh"

module qfb_ctrl (
  input  wire        pclk,           // bus clock, 20 MHz
  input  wire        presetn,        // async reset, active low
  input  wire [7:0]  paddr,          // apb byte address
  input  wire        psel,           // apb select
  input  wire        penable,        // apb access phase
  input  wire        pwrite,         // apb write
  input  wire [31:0] pwdata,         // apb write data
  output reg  [31:0] prdata,         // apb read data
  output wire        pready,         // apb ready
  output wire        pslverr,        // apb error on unmapped offset
  input  wire        mm_valid,       // mapped read request
  input  wire [31:0] mm_addr,        // mapped read address
  input  wire [1:0]  mm_size,        // 0:8 1:16 2:32 3:64 bits
  output wire        mm_ready,       // read answered
  output reg  [63:0] mm_rdata,       // aligned doubleword
  output wire        flash_serial_clock,   // serial clock pin
  output wire        flash_chip_select_n,  // chip select pin, low active
  output wire [3:0]  flash_io_out,   // io pin drive values
  output reg  [3:0]  flash_io_oe,    // io pin enables
  input  wire [3:0]  flash_io_in     // io pin levels
);
  localparam ST_IDLE = 3'd0, ST_LEAD = 3'd1, ST_NEXT = 3'd2;
  localparam ST_SHIFT = 3'd3, ST_DRAIN = 3'd4, ST_GAP = 3'd5;
  localparam integer LEAD_CNT = `QFB_SCLK_CYC - 1;

  reg [31:0] mcmd_q, madr_q, mopt_q, men_q, mwr_q, rword_q;
  reg [31:0] dcmd_q, dopt_q, den_q;
  reg        mhold_q, rxal_q, txal_q, bon_q, bhold_q;
  reg [3:0]  blen_q;

  wire ofs_ok = (paddr == `QFB_OFS_MCMD) || (paddr == `QFB_OFS_MADR) ||
                (paddr == `QFB_OFS_MOPT) || (paddr == `QFB_OFS_MEN) ||
                (paddr == `QFB_OFS_MRD) || (paddr == `QFB_OFS_MWR) ||
                (paddr == `QFB_OFS_MCTL) || (paddr == `QFB_OFS_DCMD) ||
                (paddr == `QFB_OFS_DOPT) || (paddr == `QFB_OFS_DEN) ||
                (paddr == `QFB_OFS_DCTL);
  wire wr = psel & penable & pwrite & ofs_ok;
  wire start_pulse = wr & (paddr == `QFB_OFS_MCTL) & pwdata[`QFB_START_BIT];
  wire flush_pulse = wr & (paddr == `QFB_OFS_DCTL) & pwdata[`QFB_FLUSH_BIT];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~ofs_ok;

  // engine state
  reg [2:0]  st_q, ph_q, tdly_q;
  reg        sclk_q, cs_q, held_q, held_map_q, gap_go_q, mapped_q, burst_q;
  reg        pend_q, resp_q, tx_q, rx_q, cvalid_q;
  reg [1:0]  w_q;
  reg [10:0] cnt_q;
  reg [31:0] sh_q, rx32_q;
  reg [7:0]  rx8_q;
  reg [2:0]  rxb_q, bpos_q;
  reg [63:0] acc_q;
  reg [3:0]  wdw_q;
  reg [4:0]  clen_q;
  reg [20:0] cbase_q, next_dw_q;
  reg [5:0]  rdly_q;
  reg [63:0] cache_mem [0:15];
  reg [3:0]  io_s1_q, io_s2_q, io_s3_q, io_filt_q;

  // apb register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcmd_q <= `QFB_RST_REG;
      madr_q <= `QFB_RST_REG;
      mopt_q <= `QFB_RST_REG;
      men_q <= `QFB_RST_REG;
      mwr_q <= `QFB_RST_REG;
      dcmd_q <= `QFB_RST_REG;
      dopt_q <= `QFB_RST_REG;
      den_q <= `QFB_RST_REG;
      mhold_q <= 1'b0;
      rxal_q <= 1'b0;
      txal_q <= 1'b0;
      bon_q <= 1'b0;
      bhold_q <= 1'b0;
      blen_q <= 4'h0;
    end else if (wr) begin
      case (paddr)
        `QFB_OFS_MCMD: mcmd_q <= pwdata;
        `QFB_OFS_MADR: madr_q <= pwdata;
        `QFB_OFS_MOPT: mopt_q <= pwdata;
        `QFB_OFS_MEN:  men_q <= pwdata;
        `QFB_OFS_MWR:  mwr_q <= pwdata;
        `QFB_OFS_DCMD: dcmd_q <= pwdata;
        `QFB_OFS_DOPT: dopt_q <= pwdata;
        `QFB_OFS_DEN:  den_q <= pwdata;
        `QFB_OFS_MCTL: begin
          mhold_q <= pwdata[`QFB_MHOLD_BIT];
          rxal_q <= pwdata[`QFB_RXAL_BIT];
          txal_q <= pwdata[`QFB_TXAL_BIT];
        end
        `QFB_OFS_DCTL: begin
          bon_q <= pwdata[`QFB_BON_BIT];
          bhold_q <= pwdata[`QFB_BHOLD_BIT];
          blen_q <= pwdata[`QFB_BLEN_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle, stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      case (paddr)
        `QFB_OFS_MCMD: prdata <= mcmd_q;
        `QFB_OFS_MADR: prdata <= madr_q;
        `QFB_OFS_MOPT: prdata <= mopt_q;
        `QFB_OFS_MEN:  prdata <= men_q;
        `QFB_OFS_MRD:  prdata <= rword_q;
        `QFB_OFS_MWR:  prdata <= mwr_q;
        `QFB_OFS_MCTL: prdata <= {23'h0, mhold_q, 5'h0, rxal_q, txal_q,
                                  (pend_q | (st_q != ST_IDLE))};
        `QFB_OFS_DCMD: prdata <= dcmd_q;
        `QFB_OFS_DOPT: prdata <= dopt_q;
        `QFB_OFS_DEN:  prdata <= den_q;
        `QFB_OFS_DCTL: prdata <= {7'h0, bhold_q, 4'h0, blen_q, 7'h0, bon_q,
                                  6'h0, cvalid_q, held_q};
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  // mapped mode reads its own register set
  wire [31:0] cmd_r = mapped_q ? dcmd_q : mcmd_q;
  wire [31:0] en_r  = mapped_q ? den_q : men_q;
  wire [31:0] opt_r = mapped_q ? dopt_q : mopt_q;
  wire [3:0]  adrl  = en_r[`QFB_ADRL_LSB +: 4];
  wire [3:0]  optl  = en_r[`QFB_OPTL_LSB +: 4];
  wire [3:0]  xfrl  = men_q[`QFB_XFRL_LSB +: 4];
  wire [10:0] xfr_bits = xfrl[0] ? 11'd32 : (xfrl[2] ? 11'd16 : 11'd8);
  wire [10:0] opt_bytes = {10'h0, optl[3]} + {10'h0, optl[2]} +
                          {10'h0, optl[1]} + {10'h0, optl[0]};
  wire [20:0] req_dw = mm_addr[23:3];
  wire [20:0] dw_off = req_dw - cbase_q;
  wire        in_win = (mm_addr[31:26] == `QFB_WIN_MAIN) ||
                       (mm_addr[31:26] == `QFB_WIN_ALIAS);
  wire        c_hit = cvalid_q && (dw_off < {16'h0, clen_q});
  wire        cont_ok = held_q & held_map_q & bhold_q & (req_dw == next_dw_q);

  // current phase descriptor
  reg        ph_en, ph_tx, ph_rx;
  reg [1:0]  ph_w;
  reg [10:0] ph_bits;
  reg [31:0] ph_data;
  always @* begin
    ph_en = 1'b0;
    ph_tx = 1'b1;
    ph_rx = 1'b0;
    ph_w = `QFB_W_SINGLE;
    ph_bits = 11'd8;
    ph_data = 32'h00000000;
    case (ph_q)
      3'd0: begin
        ph_en = en_r[`QFB_CMDON_BIT];
        ph_w = en_r[`QFB_CMDW_LSB +: 2];
        ph_data = {cmd_r[`QFB_CMD_LSB +: 8], 24'h0};
      end
      3'd1: begin
        ph_en = en_r[`QFB_OCMDON_BIT];
        ph_w = en_r[`QFB_OCMDW_LSB +: 2];
        ph_data = {cmd_r[`QFB_SECOND_COMMAND_CODE_LSB +: 8], 24'h0};
      end
      3'd2: begin
        ph_en = (adrl != 4'h0);
        ph_w = en_r[`QFB_ADRW_LSB +: 2];
        if (mapped_q) begin
          ph_bits = 11'd24;
          ph_data = burst_q ? {req_dw, 3'b000, 8'h0} : {mm_addr[23:0], 8'h0};
        end else if (adrl == `QFB_ADR_32) begin
          ph_bits = 11'd32;
          ph_data = madr_q;
        end else begin
          ph_bits = 11'd24;
          ph_data = {madr_q[23:0], 8'h0};
        end
      end
      3'd3: begin
        ph_en = (optl != 4'h0);
        ph_w = en_r[`QFB_OPTW_LSB +: 2];
        ph_bits = {opt_bytes[7:0], 3'b000};
        ph_data = opt_r;
      end
      3'd4: begin
        ph_w = en_r[`QFB_XFRW_LSB +: 2];
        if (mapped_q) begin
          ph_en = 1'b1;
          ph_tx = 1'b0;
          ph_rx = 1'b1;
          ph_bits = burst_q ? {clen_q, 6'h00} :
                    (11'd8 << mm_size);
        end else begin
          ph_en = (xfrl != 4'h0);
          ph_tx = txal_q;
          ph_rx = rxal_q;
          ph_bits = xfr_bits;
          ph_data = mwr_q;
        end
      end
      default: ;
    endcase
  end

  wire [10:0] step = (w_q == `QFB_W_QUAD) ? 11'd4 : ((w_q == `QFB_W_DUAL) ? 11'd2 : 11'd1);
  wire [3:0]  rbits = (w_q == `QFB_W_QUAD) ? io_filt_q :
                      ((w_q == `QFB_W_DUAL) ? {2'b00, io_filt_q[1:0]} : {3'b000, io_filt_q[1]});
  wire [7:0]  rx8_n = (w_q == `QFB_W_QUAD) ? {rx8_q[3:0], rbits} :
                      ((w_q == `QFB_W_DUAL) ? {rx8_q[5:0], rbits[1:0]} : {rx8_q[6:0], rbits[0]});
  wire [2:0]  rxb_n = rxb_q + step[2:0];

  // pin inputs: three stages, a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
      io_s3_q <= 4'h0;
      io_filt_q <= 4'h0;
    end else begin
      io_s1_q <= flash_io_in;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
      io_filt_q <= (~(io_s2_q ^ io_s3_q) & io_s3_q) | ((io_s2_q ^ io_s3_q) & io_filt_q);
    end
  end

  assign flash_serial_clock  = sclk_q;
  assign flash_chip_select_n = ~cs_q;
  assign flash_io_out = (w_q == `QFB_W_QUAD) ? sh_q[31:28] :
                        ((w_q == `QFB_W_DUAL) ? {2'b00, sh_q[31:30]} : {3'b000, sh_q[31]});
  assign mm_ready = resp_q;

  // cache array has no reset; validity is tracked separately
  always @(posedge pclk) begin
    if (rdly_q[`QFB_RX_LAG-1] && mapped_q && burst_q && (rxb_n == 3'd0) && (bpos_q == 3'd7))
      cache_mem[wdw_q] <= {rx8_n, acc_q[55:0]};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      ph_q <= 3'd0;
      tdly_q <= 3'd0;
      sclk_q <= 1'b0;
      cs_q <= 1'b0;
      held_q <= 1'b0;
      held_map_q <= 1'b0;
      gap_go_q <= 1'b0;
      mapped_q <= 1'b0;
      burst_q <= 1'b0;
      pend_q <= 1'b0;
      resp_q <= 1'b0;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
      cvalid_q <= 1'b0;
      w_q <= `QFB_W_SINGLE;
      cnt_q <= 11'd0;
      sh_q <= 32'h00000000;
      rx32_q <= 32'h00000000;
      rx8_q <= 8'h00;
      rxb_q <= 3'd0;
      bpos_q <= 3'd0;
      acc_q <= 64'h0;
      wdw_q <= 4'h0;
      clen_q <= 5'd0;
      cbase_q <= 21'd0;
      next_dw_q <= 21'd0;
      rdly_q <= 6'd0;
      rword_q <= `QFB_RST_REG;
      mm_rdata <= 64'h0;
      flash_io_oe <= 4'h0;
    end else begin
      resp_q <= 1'b0;
      if (start_pulse)
        pend_q <= 1'b1;
      if (flush_pulse)
        cvalid_q <= 1'b0;
      // receive sample taken a fixed lag after each rising edge
      rdly_q <= {rdly_q[4:0], (st_q == ST_SHIFT) & ~sclk_q & rx_q};
      if (rdly_q[`QFB_RX_LAG-1]) begin
        rx32_q <= (rx32_q << step) | {28'h0, rbits};
        rx8_q <= rx8_n;
        rxb_q <= rxb_n;
        if (rxb_n == 3'd0) begin
          acc_q[{bpos_q, 3'b000} +: 8] <= rx8_n;
          bpos_q <= bpos_q + 3'd1;
          if (burst_q && (bpos_q == 3'd7))
            wdw_q <= wdw_q + 4'h1;
        end
      end
      case (st_q)
        ST_IDLE: begin
          tdly_q <= LEAD_CNT[2:0];
          rx32_q <= 32'h00000000;
          rxb_q <= 3'd0;
          ph_q <= 3'd0;
          if (pend_q) begin
            pend_q <= start_pulse;
            mapped_q <= 1'b0;
            burst_q <= 1'b0;
            if (held_q & ~held_map_q) begin
              st_q <= ST_NEXT;
            end else if (held_q) begin
              cs_q <= 1'b0;
              held_q <= 1'b0;
              gap_go_q <= 1'b1;
              st_q <= ST_GAP;
            end else begin
              cs_q <= 1'b1;
              st_q <= ST_LEAD;
            end
          end else if (mm_valid & ~resp_q) begin
            if (!in_win) begin
              resp_q <= 1'b1;
              mm_rdata <= 64'h0;
            end else if (bon_q & c_hit) begin
              resp_q <= 1'b1;
              mm_rdata <= cache_mem[dw_off[3:0]];
            end else begin
              mapped_q <= 1'b1;
              burst_q <= bon_q;
              acc_q <= 64'h0;
              wdw_q <= 4'h0;
              bpos_q <= bon_q ? 3'd0 : mm_addr[2:0];
              if (bon_q) begin
                cbase_q <= req_dw;
                clen_q <= {1'b0, blen_q} + 5'd1;
                cvalid_q <= 1'b0;
              end
              if (bon_q & cont_ok) begin
                ph_q <= 3'd4;
                st_q <= ST_NEXT;
              end else if (held_q) begin
                cs_q <= 1'b0;
                held_q <= 1'b0;
                gap_go_q <= 1'b1;
                st_q <= ST_GAP;
              end else begin
                cs_q <= 1'b1;
                st_q <= ST_LEAD;
              end
            end
          end
        end
        ST_LEAD: begin
          if (tdly_q == 3'd0)
            st_q <= ST_NEXT;
          else
            tdly_q <= tdly_q - 3'd1;
        end
        ST_NEXT: begin
          if (ph_q > 3'd4) begin
            st_q <= ST_DRAIN;
            flash_io_oe <= 4'h0;
          end else if (ph_en) begin
            sh_q <= ph_data;
            cnt_q <= ph_bits;
            w_q <= ph_w;
            tx_q <= ph_tx;
            rx_q <= ph_rx;
            flash_io_oe <= ~ph_tx ? 4'h0 : ((ph_w == `QFB_W_QUAD) ? 4'hf :
                           ((ph_w == `QFB_W_DUAL) ? 4'h3 : 4'h1));
            st_q <= ST_SHIFT;
          end else begin
            ph_q <= ph_q + 3'd1;
          end
        end
        ST_SHIFT: begin
          sclk_q <= ~sclk_q;
          if (sclk_q) begin
            sh_q <= sh_q << step;
            if (cnt_q <= step) begin
              ph_q <= ph_q + 3'd1;
              rx_q <= 1'b0;
              st_q <= ST_NEXT;
            end else begin
              cnt_q <= cnt_q - step;
            end
          end
        end
        ST_DRAIN: begin
          tdly_q <= LEAD_CNT[2:0];
          gap_go_q <= 1'b0;
          if (rdly_q == 6'd0) begin
            if (!mapped_q) begin
              if (rxal_q && (xfrl != 4'h0))
                rword_q <= rx32_q << (6'd32 - xfr_bits[5:0]);
              held_q <= mhold_q;
              held_map_q <= 1'b0;
            end else if (burst_q) begin
              cvalid_q <= 1'b1;
              held_q <= bhold_q;
              held_map_q <= 1'b1;
              next_dw_q <= cbase_q + {16'h0, clen_q};
            end else begin
              mm_rdata <= acc_q;
              resp_q <= 1'b1;
              held_q <= 1'b0;
            end
            if ((!mapped_q && mhold_q) || (mapped_q && burst_q && bhold_q)) begin
              st_q <= ST_IDLE;
            end else begin
              cs_q <= 1'b0;
              st_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (tdly_q == 3'd0) begin
            tdly_q <= LEAD_CNT[2:0];
            if (gap_go_q) begin
              cs_q <= 1'b1;
              st_q <= ST_LEAD;
            end else begin
              st_q <= ST_IDLE;
            end
          end else begin
            tdly_q <= tdly_q - 3'd1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // qfb_ctrl

// >>> test/qfb_ctrl_assertions.sv
// port-level checks for the serial flash bus controller
`include "qfb_defs.vh"
module qfb_ctrl_chk (
  input wire        pclk,                 // bus clock
  input wire        presetn,              // reset, low active
  input wire [7:0]  paddr,                // apb address
  input wire        psel,                 // apb select
  input wire        penable,              // apb access
  input wire        pwrite,               // apb write
  input wire [31:0] pwdata,               // apb write data
  input wire [31:0] prdata,               // apb read data
  input wire        pready,               // apb ready
  input wire        pslverr,              // apb error
  input wire        mm_valid,             // mapped request
  input wire [31:0] mm_addr,              // mapped address
  input wire [1:0]  mm_size,              // mapped size
  input wire        mm_ready,             // mapped answer
  input wire [63:0] mm_rdata,             // mapped data
  input wire        flash_serial_clock,   // serial clock
  input wire        flash_chip_select_n,  // chip select
  input wire [3:0]  flash_io_out,         // pin values
  input wire [3:0]  flash_io_oe,          // pin enables
  input wire [3:0]  flash_io_in           // pin levels
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire inwin = mm_addr[31:26] == `QFB_WIN_MAIN || mm_addr[31:26] == `QFB_WIN_ALIAS;

  a_clk_idle_low: assert property (flash_chip_select_n |-> !flash_serial_clock)
    else $error("serial clock moved while deselected");
  a_clk_high_one: assert property ($rose(flash_serial_clock) |=> !flash_serial_clock)
    else $error("serial clock high longer than one cycle");
  a_data_hold: assert property (flash_serial_clock |-> $stable(flash_io_out))
    else $error("pin data changed while clock high");
  a_cs_lead: assert property ($fell(flash_chip_select_n) |-> (!flash_serial_clock) [*2])
    else $error("clock started without lead");
  a_cs_gap: assert property ($rose(flash_chip_select_n) |-> flash_chip_select_n [*2])
    else $error("select reasserted too soon");
  a_oe_idle: assert property (flash_chip_select_n && $past(flash_chip_select_n) |->
    flash_io_oe == 4'h0)
    else $error("pins driven while deselected");
  a_mm_pulse: assert property (mm_ready |=> !mm_ready)
    else $error("mapped answer longer than one cycle");
  a_mm_bound: assert property ($rose(mm_valid) |-> ##[1:1000] mm_ready)
    else $error("mapped read never answered");
  a_out_zero: assert property (mm_ready && mm_valid && !inwin |-> mm_rdata == 64'h0)
    else $error("read outside window returned data");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("bus error outside access phase");

  c_mm: cover property (mm_ready && mm_valid && inwin);
  c_sel: cover property ($fell(flash_chip_select_n));
  c_err: cover property (pslverr);
endmodule // qfb_ctrl_chk

bind qfb_ctrl qfb_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mm_valid(mm_valid), .mm_addr(mm_addr),
  .mm_size(mm_size), .mm_ready(mm_ready), .mm_rdata(mm_rdata),
  .flash_serial_clock(flash_serial_clock), .flash_chip_select_n(flash_chip_select_n),
  .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe), .flash_io_in(flash_io_in));

// >>> test/qfb_flash_model.sv
// behavioural quad serial flash: 8 cmd bits, 6 address and 2 mode groups, then data
module qfb_flash_model (
  input  wire        sclk,  // serial clock
  input  wire        cs_n,  // chip select, low active
  input  wire  [3:0] io,    // resolved pin levels
  output logic [3:0] drv    // flash drive values
);
  timeunit 1ns;
  timeprecision 1ns;
  int          n = 0;
  logic [7:0]  cmd = 0;
  logic [7:0]  mb = 0;
  logic [23:0] adr = 0;
  logic [31:0] sent = 0;
  logic [7:0]  b;
  initial drv = 4'h0;
  function automatic [7:0] fd(input [23:0] a);
    fd = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
  endfunction
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      n <= (mb[7:4] == 4'ha) ? 8 : 0; // mode byte Ax skips the next command
    end else begin
      if (n < 8) cmd <= {cmd[6:0], io[0]};
      else if (n < 14) adr <= {adr[19:0], io};
      else if (n < 16) mb <= {mb[3:0], io};
      else sent <= {sent[27:0], io};
      n <= n + 1;
    end
  end
  // output lags the falling edge, as a real part's valid time does
  always @(negedge sclk or posedge cs_n) begin
    b = fd(adr + 24'((n - 16) >> 1)); // address increments and wraps past the top
    if (!cs_n && n >= 16 && cmd == 8'heb) drv <= #5 (n[0] ? b[3:0] : b[7:4]);
    else drv <= #5 ~drv;
  end
endmodule // qfb_flash_model

// >>> test/qfb_ctrl_tb_top.sv
// self-checking bench for the serial flash bus controller
`include "qfb_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module qfb_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0;
  logic        presetn = 0;
  logic [7:0]  paddr = 0;
  logic        psel = 0, penable = 0, pwrite = 0, mm_valid = 0;
  logic [31:0] pwdata = 0, mm_addr = 0, prdata, r, v, a;
  logic [1:0]  mm_size = 0;
  logic        pready, pslverr, mm_ready, sclk, cs_n;
  logic [63:0] mm_rdata;
  logic [3:0]  io_out, io_oe, io_drv;
  wire  [3:0]  io_pin = (io_oe & io_out) | (~io_oe & io_drv);
  int          mismatches = 0, tests_run = 0, cyc = 0, sel_cnt = 0, s;
  logic [64:0] aq[$], ea;
  logic [127:0] mq[$], em;
  logic [7:0]  ofs [11] = '{`QFB_OFS_MCMD, `QFB_OFS_MADR, `QFB_OFS_MOPT, `QFB_OFS_MEN,
    `QFB_OFS_MWR, `QFB_OFS_DCMD, `QFB_OFS_DOPT, `QFB_OFS_DEN, `QFB_OFS_MRD,
    `QFB_OFS_MCTL, `QFB_OFS_DCTL};
  logic [31:0] msk [8] = '{32'h00ff00ff, '1, '1, 32'hf3335fff, '1, 32'h00ff00ff, '1,
    32'hf3335ff0};
  logic [3:0]  lens [3] = '{4'hf, 4'hc, 4'h8};
  logic [31:0] lm [3] = '{32'hffffffff, 32'hffff0000, 32'hff000000};
  always #25 pclk = ~pclk;
  qfb_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mm_valid(mm_valid), .mm_addr(mm_addr),
    .mm_size(mm_size), .mm_ready(mm_ready), .mm_rdata(mm_rdata),
    .flash_serial_clock(sclk), .flash_chip_select_n(cs_n), .flash_io_out(io_out),
    .flash_io_oe(io_oe), .flash_io_in(io_pin));
  qfb_flash_model fm (.sclk(sclk), .cs_n(cs_n), .io(io_pin), .drv(io_drv));
  function automatic [7:0] fd(input [23:0] x);
    fd = x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5a;
  endfunction
  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // e = {error expected, compare mask, value}; a zero entry only keeps the queue aligned
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
    input logic [64:0] e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    if (!w) aq.push_back(e);
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic mm(input logic [31:0] ad, input logic [1:0] z);
    logic [127:0] x;
    x = 0;
    for (int i = 0; i < (1 << z); i++) begin
      x[64 + (ad[2:0] + i) * 8 +: 8] = 8'hff;
      x[(ad[2:0] + i) * 8 +: 8] = fd(ad[23:0] + 24'(i));
    end
    if (ad[31:26] != `QFB_WIN_MAIN && ad[31:26] != `QFB_WIN_ALIAS) x = {{64{1'b1}}, 64'h0};
    mq.push_back(x);
    @(posedge pclk);
    mm_valid <= 1;
    mm_addr <= ad;
    mm_size <= z;
    @(posedge pclk);
    while (!mm_ready) @(posedge pclk);
    mm_valid <= 0;
  endtask
  task automatic wait_idle();
    r = 1;
    while (r[0]) apb(0, `QFB_OFS_MCTL, 0, 0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      ea = aq.pop_front();
      if (ea[64] || ea[63:32] != 0) `CHK({pslverr, prdata & ea[63:32]}, ea[64:64+0] ? {1'b1, 32'h0} : {1'b0, ea[31:0]})
    end
    if (mm_ready) begin
      em = mq.pop_front();
      `CHK(mm_rdata & em[127:64], em[63:0])
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(negedge cs_n) sel_cnt++;
  initial begin
    void'($urandom(91055));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    foreach (ofs[i]) apb(0, ofs[i], 0, {1'b0, 32'hffffffff, `QFB_RST_REG});
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      apb(1, ofs[i], v, 0);
      apb(0, ofs[i], 0, {1'b0, msk[i], v & msk[i]});
    end
    apb(1, `QFB_OFS_MRD, '1, 0);
    apb(0, `QFB_OFS_MRD, 0, {1'b0, 32'hffffffff, 32'h0});
    apb(0, 8'h30, 0, {1'b1, 64'h0});
    apb(1, `QFB_OFS_MCMD, 32'h00eb0000, 0);
    apb(1, `QFB_OFS_MOPT, 32'h0, 0);
    foreach (lens[k]) begin
      v = (k == 0) ? 32'h00fffffe : $urandom & 32'h00ffffff;
      apb(1, `QFB_OFS_MADR, v, 0);
      apb(1, `QFB_OFS_MEN, {28'h0222478, lens[k]}, 0); // select never held on quad reads
      apb(1, `QFB_OFS_MCTL, 32'h5, 0); // no mapped read open during manual work
      wait_idle();
      apb(0, `QFB_OFS_MRD, 0, {1'b0, lm[k], {fd(v), fd(v + 1), fd(v + 2), fd(v + 3)} & lm[k]});
    end
    v = $urandom;
    apb(1, `QFB_OFS_MCMD, 32'h00320000, 0);
    apb(1, `QFB_OFS_MADR, 32'h00000100, 0); // four bytes stay inside one page
    apb(1, `QFB_OFS_MEN, 32'h0222478f, 0);
    apb(1, `QFB_OFS_MWR, v, 0);
    apb(1, `QFB_OFS_MCTL, 32'h3, 0);
    wait_idle();
    `CHK(fm.sent, v)
    apb(1, `QFB_OFS_DCMD, 32'h00eb0000, 0);
    apb(1, `QFB_OFS_DOPT, 32'h0, 0);
    apb(1, `QFB_OFS_DEN, 32'h0222478f, 0);
    apb(1, `QFB_OFS_DCTL, 32'h0, 0);
    for (int z = 0; z < 4; z++) begin
      v = $urandom;
      mm({2'b00, v[31], 3'b110, v[25:0]} & (32'hffffffff << z), 2'(z));
    end
    mm({8'h40, v[23:2], 2'b00}, 2);
    // burst with two doublewords per fill
    apb(1, `QFB_OFS_DCTL, 32'h00010100, 0);
    a = {8'h18, v[23:4], 4'h0};
    s = sel_cnt;
    mm(a, 3);
    mm(a + 8, 3);
    `CHK(sel_cnt, s + 1)
    apb(1, `QFB_OFS_DCTL, 32'h00010300, 0);
    mm(a + 8, 3);
    `CHK(sel_cnt, s + 2)
    apb(1, `QFB_OFS_DCTL, 32'h01010100, 0);
    mm(a + 64, 3);
    mm(a + 80, 3);
    `CHK(sel_cnt, s + 3)
    mm(a, 3);
    `CHK(sel_cnt, s + 4)
    repeat (4) @(posedge pclk);
    finish_test();
  end
endmodule // qfb_ctrl_tb_top
